//--- include/dac_ctrl_pkg.sv
// Types shared by the DAC control register logic
package dac_ctrl_pkg;

  localparam int BUS_W  = 10;
  localparam int MAIN_W = 10;
  localparam int SUB_W  = 8;

  typedef enum logic [1:0] {
    BIAS_SUPPLY_HALF,
    BIAS_INT_REF,
    BIAS_EXT_REF,
    BIAS_UNDEFINED
  } bias_src_t;

  typedef struct packed {
    logic byteMode;
    logic codingSelect;
    logic powerDownN;
    logic allStandby;
    logic allClear;
  } sys_cfg_t;

  typedef struct packed {
    bias_src_t           bias;
    logic                fineSel;
    logic                standbyN;
    logic                clr;
    logic [MAIN_W-1:0]   mainIn;
    logic [SUB_W-1:0]    subIn;
    logic [MAIN_W-1:0]   mainOut;
    logic [SUB_W-1:0]    subOut;
  } chan_state_t;

endpackage

//--- include/dac_ctrl_regs.svh
// Bit positions, reset values and clear codes of the DAC control registers
`ifndef DAC_CTRL_REGS_SVH
`define DAC_CTRL_REGS_SVH

// ----------------------------------------------------------------
// Data bus layout
// ----------------------------------------------------------------
`define DB_SEL_BIT       0
`define DB_BYTE_BIT      1
`define DB_WORD_MSB      9
`define DB_WORD_LSB      0
`define DB_HIGH_MSB      9
`define DB_HIGH_LSB      2
`define DB_LOWPAIR_MSB   3
`define DB_LOWPAIR_LSB   2
`define MAIN_HIGH_MSB    9
`define MAIN_HIGH_LSB    2
`define MAIN_LOW_MSB     1
`define MAIN_LOW_LSB     0

// ----------------------------------------------------------------
// System configuration register fields
// ----------------------------------------------------------------
`define SYS_BYTE_BIT     7
`define SYS_CODING_BIT   6
`define SYS_PDN_BIT      5
`define SYS_CHAN_STANDBY_N_BIT     4
`define SYS_CLR_BIT      3

// ----------------------------------------------------------------
// Channel configuration register fields
// ----------------------------------------------------------------
`define CH_BIAS_MSB      9
`define CH_BIAS_LSB      8
`define CH_FINE_BIT      7
`define CH_STBYN_BIT     4
`define CH_CLR_BIT       3

// ----------------------------------------------------------------
// Power-on values
// ----------------------------------------------------------------
`define RST_BYTE_MODE    1'h0
`define RST_CODING       1'h1
`define RST_PDN          1'h1
`define RST_ALL_CHAN_STANDBY_N     1'h1
`define RST_ALL_CLR      1'h0
`define RST_FINE         1'h0
`define RST_CH_STBYN     1'h1
`define RST_CH_CLR       1'h1

// ----------------------------------------------------------------
// Clear codes
// ----------------------------------------------------------------
`define MAIN_CLR_OB      10'h000
`define MAIN_CLR_TC      10'h000
`define SUB_MID_OB       8'h80
`define SUB_MID_TC       8'h00

`endif

//--- tb/dac_ctrl_checker.sv
// Port-level assertions for the DAC control register logic
`timescale 1ns/1ps
`default_nettype none

module dac_ctrl_checker #(
  parameter int NUM_CH = 8,
  parameter int ADDR_W = 3
) (
  input wire logic                                   mclk,
  input wire logic                                   sys_rst,
  input wire logic                                   csN,
  input wire logic                                   wrN,
  input wire logic                                   mode,
  input wire logic [ADDR_W-1:0]                      chanAddr,
  input wire logic [dac_ctrl_pkg::BUS_W-1:0]         dataBus,
  input wire logic                                   loadOutputsN,
  input wire logic                                   hwClearN,
  input wire logic [NUM_CH*dac_ctrl_pkg::MAIN_W-1:0] mainCodes,
  input wire logic [NUM_CH*dac_ctrl_pkg::SUB_W-1:0]  subCodes,
  input wire logic [NUM_CH*2-1:0]                    biasSels,
  input wire logic [NUM_CH-1:0]                      chanActive,
  input wire logic                                   refEnable,
  input wire logic                                   codingSelect,
  input wire logic                                   byteMode,
  input wire logic                                   allStandby
);
  import dac_ctrl_pkg::*;
  typedef struct packed {logic wr; logic ld;} hist_t;
  hist_t      hist_r;
  hist_t      hist_nxt;
  logic       take;
  logic       ldFall;
  logic [3:0] sysField;
  logic [1:0] biasField;
  // -----------------------------------------------
  // Strobe history, reset high like the design's
  // -----------------------------------------------
  always_comb begin
    hist_nxt.wr = wrN;
    hist_nxt.ld = loadOutputsN;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) hist_r <= 2'h3;
    else hist_r <= hist_nxt;
  end
  assign take = !csN && wrN && !hist_r.wr;
  assign ldFall = hist_r.ld && !loadOutputsN;
  assign sysField = dataBus[7:4];
  assign biasField = dataBus[9:8];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ref_source_a: assert property ($changed(refEnable) |-> $past(take))
    else $error("reference enable moved without a write");
  hw_main_a: assert property (!hwClearN |=> mainCodes == '0)
    else $error("main codes not cleared by hardware clear");
  hw_sub_a: assert property ((!hwClearN && !take) |=>
    subCodes == {NUM_CH{$past(codingSelect) ? 8'h80 : 8'h00}}) else $error("sub codes not at zero contribution");
  standby_gate_a: assert property (|chanActive |-> refEnable && !allStandby)
    else $error("channel active while powered down or in standby");
  cs_ignore_a: assert property ((wrN && !hist_r.wr && csN && loadOutputsN && hist_r.ld && hwClearN) |=>
    $stable(biasSels) && $stable(refEnable) && $stable(codingSelect) && $stable(byteMode)) else $error("deselected write took effect");
  sys_write_a: assert property ((take && !mode && !dataBus[0] && hwClearN) |=>
    {byteMode, codingSelect, refEnable, allStandby} == $past(sysField)) else $error("system write not applied");
  bias_write_a: assert property ((take && !mode && dataBus[0] && hwClearN) |=>
    biasSels[$past(chanAddr)*2 +: 2] == $past(biasField)) else $error("bias select not applied");
  code_cause_a: assert property (($changed(mainCodes) || $changed(subCodes)) |->
    $past(take || ldFall || !hwClearN)) else $error("output codes moved without cause");
endmodule // dac_ctrl_checker

bind dac_control_register_logic dac_ctrl_checker #(.NUM_CH(NUM_CH), .ADDR_W(ADDR_W)) i_chk (
  .mclk, .sys_rst, .csN, .wrN, .mode, .chanAddr, .dataBus, .loadOutputsN, .hwClearN, .mainCodes,
  .subCodes, .biasSels, .chanActive, .refEnable, .codingSelect, .byteMode, .allStandby
);
`default_nettype wire

//--- tb/dac_host_model.sv
// Host processor driving the parallel write port
`timescale 1ns/1ps
`default_nettype none

module dac_host_model #(
  parameter int ADDR_W = 3
) (
  input  wire logic                          mclk,
  output logic                               csN,
  output logic                               wrN,
  output logic                               mode,
  output logic [ADDR_W-1:0]                  chanAddr,
  output logic [dac_ctrl_pkg::BUS_W-1:0]     dataBus,
  output logic                               loadOutputsN,
  output logic                               hwClearN
);
  import dac_ctrl_pkg::*;
  initial begin
    {csN, wrN, mode, loadOutputsN, hwClearN} = 5'h1B;
    chanAddr = '0;
    dataBus = '0;
  end
  // Strobe low one cycle, high with data held, then release
  task automatic wr(input logic m, input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d,
                    input logic ld, input logic cs);
    @(negedge mclk);
    csN = cs;
    wrN = 1'h0;
    mode = m;
    chanAddr = a;
    dataBus = d;
    loadOutputsN = ld;
    @(negedge mclk);
    wrN = 1'h1;
    @(negedge mclk);
    csN = 1'h1;
    loadOutputsN = 1'h1;
    // Released bus shows the inverse so stale data cannot pass
    dataBus = ~d;
  endtask
  task automatic ldp;
    @(negedge mclk);
    loadOutputsN = 1'h0;
    @(negedge mclk);
    loadOutputsN = 1'h1;
  endtask
  task automatic hwc(input logic lv);
    @(negedge mclk);
    hwClearN = lv;
  endtask
endmodule // dac_host_model
`default_nettype wire

//--- tb/test_dac_control_register_logic.sv
// Self-checking bench for the DAC control register logic
`timescale 1ns/1ps
`default_nettype none

module test_dac_control_register_logic;
  import dac_ctrl_pkg::*;
  typedef struct {int kind; int ch; logic [9:0] v;} note_t;
  logic mclk, sys_rst, csN, wrN, mode, loadOutputsN, hwClearN;
  logic refEnable, codingSelect, byteMode, allStandby;
  logic [2:0] chanAddr;
  logic [9:0] dataBus, a, d, hb, gotVal;
  logic [79:0] mainCodes;
  logic [63:0] subCodes;
  logic [15:0] biasSels;
  logic [7:0] chanActive, s;
  logic [1:0] c, o, lp;
  int badCount, numChecks, cycles, seedVal;
  note_t q[$];
  note_t n;
  event chk;

  dac_host_model #(.ADDR_W(3)) i_host (.mclk, .csN, .wrN, .mode, .chanAddr, .dataBus, .loadOutputsN, .hwClearN);
  dac_control_register_logic #(.NUM_CH(8), .ADDR_W(3)) i_dut (.mclk, .sys_rst, .csN, .wrN, .mode, .chanAddr,
    .dataBus, .loadOutputsN, .hwClearN, .mainCodes, .subCodes, .biasSels, .chanActive, .refEnable,
    .codingSelect, .byteMode, .allStandby);

  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [9:0] sysw(input logic b, cd, p, sb, k);
    return {2'h0, b, cd, p, sb, k, 3'h0};
  endfunction
  function automatic logic [9:0] chw(input logic [1:0] bs, input logic f, sn, k);
    return {bs, f, 2'h0, sn, k, 3'h1};
  endfunction
  function automatic logic [9:0] got(input int k, input int ch);
    case (k)
      0: return mainCodes[ch*MAIN_W +: MAIN_W];
      1: return {2'h0, subCodes[ch*SUB_W +: SUB_W]};
      2: return {8'h0, biasSels[ch*2 +: 2]};
      3: return {9'h0, chanActive[ch]};
      4: return {9'h0, refEnable};
      5: return {9'h0, codingSelect};
      6: return {9'h0, byteMode};
      default: return {9'h0, allStandby};
    endcase
  endfunction
  task automatic note(input int k, input int ch, input logic [9:0] v);
    q.push_back('{k, ch, v});
  endtask
  // Let the answer edge land before the watcher compares
  task automatic fire;
    repeat (2) @(negedge mclk);
    ->chk;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // -----------------------------------------------
  // Watcher and hang guard
  // -----------------------------------------------
  always begin
    @(chk);
    while (q.size() > 0) begin
      n = q.pop_front();
      gotVal = got(n.kind, n.ch);
      numChecks++;
      if (gotVal !== n.v) begin
        badCount++;
        $display("Error t=%0t got %0h exp %0h", $time, gotVal, n.v);
      end
    end
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      badCount++;
      print_verdict();
    end
  end
  // -----------------------------------------------
  // Scenarios
  // -----------------------------------------------
  initial begin
    sys_rst = 1'h1;
    repeat (8) @(negedge mclk);
    sys_rst = 1'h0;
    seedVal = $urandom(93739);
    for (int i = 0; i < 8; i++) begin
      note(0, i, 10'h000); note(1, i, 10'h080); note(2, i, 10'h000); note(3, i, 10'h000);
    end
    note(4, 0, 10'h001); note(5, 0, 10'h001); note(6, 0, 10'h000); note(7, 0, 10'h001);
    fire();
    i_host.wr(1'h0, 3'($urandom), sysw(0, 0, 1, 0, 0), 1'h1, 1'h0);
    note(5, 0, 10'h000); note(7, 0, 10'h000); note(4, 0, 10'h001); note(3, 7, 10'h001);
    fire();
    for (int b = 0; b < 4; b++) begin
      i_host.wr(1'h0, 3'(b), chw(2'(b), 0, 1, 0), 1'h1, 1'h0);
      note(2, b, 10'(b));
    end
    c = 2'($urandom);
    o = c ^ 2'h1;
    d = 10'($urandom);
    hb = 10'($urandom);
    i_host.wr(1'h1, 3'(c), d, 1'h0, 1'h0);
    i_host.wr(1'h1, 3'(o), hb, 1'h0, 1'h0);
    note(0, c, d); note(0, o, hb);
    fire();
    i_host.wr(1'h1, 3'(c), ~d, 1'h1, 1'h1);
    i_host.ldp();
    note(0, c, d);
    fire();
    a = 10'($urandom);
    i_host.wr(1'h1, 3'(c), a, 1'h1, 1'h0);
    note(0, c, d);
    fire();
    i_host.ldp();
    note(0, c, a);
    s = 8'($urandom);
    i_host.wr(1'h0, 3'(c), chw(0, 1, 1, 0), 1'h1, 1'h0);
    i_host.wr(1'h1, 3'(c), {s, 2'($urandom)}, 1'h0, 1'h0);
    note(1, c, {2'h0, s}); note(0, c, a);
    i_host.wr(1'h0, 3'(c), chw(0, 0, 1, 1), 1'h1, 1'h0);
    note(0, c, a);
    fire();
    i_host.ldp();
    note(0, c, 10'h000); note(1, c, {2'h0, s}); note(0, o, hb);
    fire();
    i_host.wr(1'h0, 3'(o), chw(0, 0, 0, 0), 1'h1, 1'h0);
    note(3, o, 10'h000); note(3, c, 10'h001); note(4, 0, 10'h001);
    i_host.wr(1'h0, 3'h0, sysw(0, 0, 1, 0, 1), 1'h1, 1'h0);
    note(0, o, 10'h000); note(1, c, {2'h0, s});
    fire();
    i_host.wr(1'h0, 3'h0, sysw(0, 0, 1, 0, 0), 1'h1, 1'h0);
    i_host.wr(1'h1, 3'(o), d, 1'h0, 1'h0);
    i_host.wr(1'h0, 3'h0, sysw(0, 0, 0, 0, 0), 1'h1, 1'h0);
    note(4, 0, 10'h000); note(3, c, 10'h000); note(0, o, d);
    fire();
    i_host.wr(1'h0, 3'h0, sysw(0, 0, 1, 0, 0), 1'h1, 1'h0);
    note(4, 0, 10'h001); note(3, c, 10'h001); note(0, o, d);
    fire();
    i_host.wr(1'h0, 3'h0, sysw(1, 1, 1, 0, 0), 1'h1, 1'h0);
    i_host.wr(1'h0, 3'h0, sysw(1, 0, 1, 0, 0) | 10'h002, 1'h1, 1'h0);
    i_host.wr(1'h0, 3'(o), chw(2, 0, 1, 0) | 10'h002, 1'h1, 1'h0);
    note(6, 0, 10'h001); note(5, 0, 10'h000); note(2, o, 10'h002);
    lp = 2'($urandom);
    i_host.wr(1'h1, 3'(o), {hb[7:0], 2'h0}, 1'h1, 1'h0);
    i_host.wr(1'h1, 3'(o), {6'h0, lp, 2'h2}, 1'h0, 1'h0);
    i_host.wr(1'h1, 3'(o), {s, 2'h3}, 1'h0, 1'h0);
    note(0, o, {hb[7:0], lp}); note(1, o, {2'h0, s});
    fire();
    for (int k = 0; k < 2; k++) begin
      i_host.wr(1'h0, 3'h0, sysw(1, k[0], 1, 0, 0), 1'h1, 1'h0);
      i_host.hwc(1'h0);
      i_host.hwc(1'h1);
      note(0, o, 10'h000); note(1, o, k ? 10'h080 : 10'h000);
      fire();
    end
    print_verdict();
  end
endmodule // test_dac_control_register_logic
`default_nettype wire

//--- verilog/dac_channel.sv
// One channel: configuration, input registers and output registers
`timescale 1ns/1ps
`default_nettype none
`include "dac_ctrl_regs.svh"

module dac_channel (
  input  wire logic                            mclk,
  input  wire logic                            sys_rst,
  input  wire logic                            cfgWe,
  input  wire logic                            dataWe,
  input  wire logic                            byteMode,
  input  wire logic                            codingSelect,
  input  wire logic [dac_ctrl_pkg::BUS_W-1:0]  dataBus,
  input  wire logic                            sysClear,
  input  wire logic                            loadEv,
  input  wire logic                            hwClearN,
  output logic      [dac_ctrl_pkg::MAIN_W-1:0] mainCode,
  output logic      [dac_ctrl_pkg::SUB_W-1:0]  subCode,
  output dac_ctrl_pkg::bias_src_t              biasSel,
  output logic                                 standbyN
);
  import dac_ctrl_pkg::*;

  chan_state_t            state_r;
  chan_state_t            state_nxt;
  logic [MAIN_W-1:0]      mainClr;
  logic [SUB_W-1:0]       subMid;
  logic                   toSub;

  always_comb begin
    state_nxt = state_r;
    mainClr   = codingSelect ? `MAIN_CLR_OB : `MAIN_CLR_TC;   // [R5] [R24]
    subMid    = codingSelect ? `SUB_MID_OB : `SUB_MID_TC;     // [R18]
    toSub     = 1'b0;
    if (cfgWe) begin
      state_nxt.bias     = bias_src_t'(dataBus[`CH_BIAS_MSB:`CH_BIAS_LSB]);  // [R6]
      state_nxt.fineSel  = dataBus[`CH_FINE_BIT];                            // [R7]
      state_nxt.standbyN = dataBus[`CH_STBYN_BIT];                           // [R8]
      state_nxt.clr      = dataBus[`CH_CLR_BIT];                             // [R9]
    end
    if (dataWe) begin
      // Byte mode picks main or sub per write, so no reconfiguration is needed
      toSub = byteMode ? dataBus[`DB_SEL_BIT] : state_r.fineSel;  // [R7] [R16]
      if (toSub) begin
        state_nxt.subIn = dataBus[`DB_HIGH_MSB:`DB_HIGH_LSB];
      end else if (!byteMode) begin
        state_nxt.mainIn = dataBus[`DB_WORD_MSB:`DB_WORD_LSB];
      end else if (!dataBus[`DB_BYTE_BIT]) begin
        state_nxt.mainIn[`MAIN_HIGH_MSB:`MAIN_HIGH_LSB] = dataBus[`DB_HIGH_MSB:`DB_HIGH_LSB];  // [R15]
      end else begin
        state_nxt.mainIn[`MAIN_LOW_MSB:`MAIN_LOW_LSB] = dataBus[`DB_LOWPAIR_MSB:`DB_LOWPAIR_LSB];  // [R15]
      end
    end
    if (loadEv) begin
      state_nxt.subOut = state_nxt.subIn;
      // Channel clear only acts on a load, and leaves the sub path alone
      if (state_nxt.clr) begin
        state_nxt.mainIn  = mainClr;  // [R9] [R10]
        state_nxt.mainOut = mainClr;
      end else begin
        state_nxt.mainOut = state_nxt.mainIn;  // [R23]
      end
    end
    if (sysClear) begin
      state_nxt.mainIn  = mainClr;  // [R4]
      state_nxt.mainOut = mainClr;
    end
    if (!hwClearN) begin
      state_nxt.mainIn  = mainClr;  // [R17]
      state_nxt.mainOut = mainClr;
      state_nxt.subIn   = subMid;   // [R18]
      state_nxt.subOut  = subMid;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r.bias     <= BIAS_SUPPLY_HALF;  // [R11]
      state_r.fineSel  <= `RST_FINE;
      state_r.standbyN <= `RST_CH_STBYN;
      state_r.clr      <= `RST_CH_CLR;
      state_r.mainIn   <= `MAIN_CLR_OB;
      state_r.subIn    <= `SUB_MID_OB;
      state_r.mainOut  <= `MAIN_CLR_OB;
      state_r.subOut   <= `SUB_MID_OB;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign mainCode = state_r.mainOut;
  assign subCode  = state_r.subOut;
  assign biasSel  = state_r.bias;
  assign standbyN = state_r.standbyN;

endmodule // dac_channel

`default_nettype wire

//--- verilog/dac_control_register_logic.sv
// Parallel host port, system configuration and per-channel control of the DAC
`timescale 1ns/1ps
`default_nettype none
`include "dac_ctrl_regs.svh"

// Summary of operation
// R1 - coding_select 0 gives twos complement, 1 gives offset binary for all channels.
// R2 - power_down_n 0 powers down everything including reference; 1 normal, default.
// R3 - all_standby 1 puts every channel in standby; powers up as 1.
// R4 - all_clear clears every main converter register, sub registers untouched.
// R5 - Main clear gives bottom-of-scale in offset binary, midscale in twos complement.
// R6 - Bias select: 00 supply half, 01 internal reference, 10 external, 11 undefined.
// R7 - In 10-bit mode fine_coarse_select routes next data write to main or sub.
// R8 - chan_standby_n 0 puts only the addressed channel in standby; 1 default.
// R9 - chan_clear 1 clears only the addressed main converter per coding.
// R10 - Channel clear takes effect only on a load pulse supplied by host.
// R11 - Power-on: all standby, reference on, channel clear set, bias select 00.
// R12 - Host writes system config, then channel configs, before converter data.
// R13 - byte_load_select 1 switches the data port to 8+2 byte loading.
// R14 - Byte mode config writes: bit1 ignored, bit0 picks system or channel.
// R15 - Byte mode data writes: bit1 low loads high eight bits, high loads two.
// R16 - Byte mode: bit0 low targets main, high targets sub converter register.
// R17 - hw_clear_n low clears every main converter according to coding.
// R18 - Hardware clear alone clears sub converters, to midscale for any coding.
// R19 - Power-down retains all register contents unchanged.
// R20 - Standby never turns off the reference; only power-down does.
// R21 - Host holds mode low for configuration, high for converter data writes.
// R22 - Host drives channel address with chip select, strobe and mode.
// R23 - load_outputs_n low at strobe rising edge updates outputs from data registers.
// R24 - Clears load the converter input register with the coding's clear code.
// R25 - Writes are captured at strobe rising edge while chip select asserted.
module dac_control_register_logic #(
  parameter int NUM_CH = 8,
  parameter int ADDR_W = 3
) (
  input  wire logic                                mclk,
  input  wire logic                                sys_rst,
  input  wire logic                                csN,
  input  wire logic                                wrN,
  input  wire logic                                mode,
  input  wire logic [ADDR_W-1:0]                   chanAddr,
  input  wire logic [dac_ctrl_pkg::BUS_W-1:0]      dataBus,
  input  wire logic                                loadOutputsN,
  input  wire logic                                hwClearN,
  output logic      [NUM_CH*dac_ctrl_pkg::MAIN_W-1:0] mainCodes,
  output logic      [NUM_CH*dac_ctrl_pkg::SUB_W-1:0]  subCodes,
  output logic      [NUM_CH*2-1:0]                 biasSels,
  output logic      [NUM_CH-1:0]                   chanActive,
  output logic                                     refEnable,
  output logic                                     codingSelect,
  output logic                                     byteMode,
  output logic                                     allStandby
);
  import dac_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sys_cfg_t            cfg;
    logic                wrPrev;
    logic                ldPrev;
    logic [NUM_CH-1:0]   active;
  } top_state_t;

  top_state_t            state_r;
  top_state_t            state_nxt;
  logic [NUM_CH-1:0]     chStandbyN;
  logic                  writeTake;
  logic                  sysWe;
  logic                  chanCfgWe;
  logic                  dataWe;
  logic                  loadEv;
  logic                  sysClear;

  function automatic logic chanHit(input logic [ADDR_W-1:0] addr, input int ch);
    chanHit = (addr == ADDR_W'(ch));
  endfunction

  // ----------------------------------------------------------------
  // Host write decode
  // ----------------------------------------------------------------
  // Strobe rising edge is seen one cycle late; address and data must
  // still be valid in the cycle after the edge, like setup/hold on a pin.
  assign writeTake = !state_r.wrPrev && wrN && !csN;  // [R25]
  assign sysWe     = writeTake && !mode && !dataBus[`DB_SEL_BIT];  // [R14]
  assign chanCfgWe = writeTake && !mode && dataBus[`DB_SEL_BIT];   // [R14]
  assign dataWe    = writeTake && mode;
  // Load on a low level at the strobe edge, or on a falling edge alone
  assign loadEv    = (writeTake && !loadOutputsN) || (state_r.ldPrev && !loadOutputsN);  // [R23]

  // ----------------------------------------------------------------
  // System configuration and status
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt        = state_r;
    state_nxt.wrPrev = wrN;
    state_nxt.ldPrev = loadOutputsN;
    if (sysWe) begin
      state_nxt.cfg.byteMode     = dataBus[`SYS_BYTE_BIT];    // [R13]
      state_nxt.cfg.codingSelect = dataBus[`SYS_CODING_BIT];  // [R1]
      state_nxt.cfg.powerDownN   = dataBus[`SYS_PDN_BIT];     // [R2]
      state_nxt.cfg.allStandby   = dataBus[`SYS_CHAN_STANDBY_N_BIT];    // [R3]
      state_nxt.cfg.allClear     = dataBus[`SYS_CLR_BIT];     // [R4]
    end
    // Standby gates channels only; the reference follows power-down alone
    for (int i = 0; i < NUM_CH; i++) begin
      state_nxt.active[i] = state_nxt.cfg.powerDownN && !state_nxt.cfg.allStandby
                            && chStandbyN[i];  // [R3] [R8] [R20]
    end
  end

  // Clearing is held for as long as the bit stays set, so main writes
  // are lost until software clears it again.
  assign sysClear = state_nxt.cfg.allClear;  // [R4]

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r.cfg.byteMode     <= `RST_BYTE_MODE;
      state_r.cfg.codingSelect <= `RST_CODING;
      state_r.cfg.powerDownN   <= `RST_PDN;       // [R11]
      state_r.cfg.allStandby   <= `RST_ALL_CHAN_STANDBY_N;  // [R11]
      state_r.cfg.allClear     <= `RST_ALL_CLR;
      state_r.wrPrev           <= 1'h1;
      state_r.ldPrev           <= 1'h1;
      state_r.active           <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // Power-down has no effect on stored contents; only chanActive and refEnable gate off.
  generate
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
      bias_src_t bias;
      dac_channel u_chan (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .cfgWe        (chanCfgWe && chanHit(chanAddr, ch)),
        .dataWe       (dataWe && chanHit(chanAddr, ch)),
        .byteMode     (state_r.cfg.byteMode),
        .codingSelect (state_r.cfg.codingSelect),
        .dataBus      (dataBus),
        .sysClear     (sysClear),
        .loadEv       (loadEv),
        .hwClearN     (hwClearN),
        .mainCode     (mainCodes[ch*MAIN_W +: MAIN_W]),
        .subCode      (subCodes[ch*SUB_W +: SUB_W]),
        .biasSel      (bias),
        .standbyN     (chStandbyN[ch])
      );  // [R19]
      assign biasSels[ch*2 +: 2] = bias;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign chanActive   = state_r.active;
  assign refEnable    = state_r.cfg.powerDownN;  // [R2] [R20]
  assign codingSelect = state_r.cfg.codingSelect;
  assign byteMode     = state_r.cfg.byteMode;
  assign allStandby   = state_r.cfg.allStandby;

endmodule // dac_control_register_logic

`default_nettype wire
